// ===== inc/dsgr_pkg.sv
// Register map, field layout and mode encodings for the sleep gating and soft reset block
package dsgr_pkg;
  localparam int unsigned ADDR_W = 12;
  // Register byte offsets
  localparam logic [11:0] OFF_SW_RESET_0 = 12'h040;
  localparam logic [11:0] OFF_SLEEP_GATE_2 = 12'h118;
  localparam logic [11:0] OFF_DEEP_SLEEP_GATE_2 = 12'h128;
  localparam logic [11:0] OFF_RUN_GATE_2 = 12'h108;
  localparam logic [11:0] OFF_RUN_CONFIG = 12'h060;
  localparam logic [11:0] OFF_CAPS_1 = 12'h010;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h150;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h154;
  // Gating fields
  localparam int unsigned GATE_USB_BIT = 16;
  localparam int unsigned GATE_DMA_BIT = 13;
  localparam int unsigned GATE_PORT_LSB = 0;
  localparam int unsigned GATE_PORTS = 5;
  localparam logic [31:0] GATE_WMASK = 32'h0001_201f;
  // Soft reset fields
  localparam int unsigned RST_CAN_BIT = 24;
  localparam int unsigned RST_ADC_BIT = 16;
  localparam int unsigned RST_HIBERNATE_BIT = 6;
  localparam int unsigned RST_WATCHDOG_BIT = 3;
  localparam logic [31:0] RST_WMASK = 32'h0101_0048;
  localparam logic [31:0] RST_RESET = 32'h0000_0000;
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;
  // Run config: auto gating select bit
  localparam int unsigned AUTO_GATE_BIT = 27;
  localparam logic [31:0] RUNCFG_WMASK = 32'h0800_0000;
  // Interrupt events
  localparam int unsigned EV_FAULT_BIT = 0;
  localparam int unsigned EV_MODE_BIT = 1;
  localparam logic [31:0] IRQ_WMASK = 32'h0000_0003;
  localparam int unsigned N_UNITS = 7;
  typedef enum logic [1:0] {
    DSGR_RUN = 2'b00,
    DSGR_SLEEP = 2'b01,
    DSGR_DEEP = 2'b10
  } dsgr_mode_type;
endpackage

// ===== hw/dsgr_top.sv
// Deep-sleep / sleep / run clock gating and software reset control with Wishbone slave
//
// Notes on behaviour
// - Gate bit one clocks the unit
// - Gate bit zero stops unit clock
// - Access to gated unit gets bus fault
// - Gating bits reset to zero
// - Deep-sleep gate applies only in deep sleep
// - Sleep gates need auto gating select set
// - USB 16, DMA 13, ports 4..0
// - Deep-sleep gate at offset 0x128
// - Reserved bits read zero, ignore writes
// - Reset writes masked by capabilities
// - CAN 24, ADC 16, hibernation 6, watchdog 3
// - Reset register 0x040, resets to zero
// - Hibernation and watchdog resets independent
// - Sleep gate 0x118, same layout
`timescale 1ns/1ps
module dsgr_top #(
  parameter logic [31:0] CAPS_1_VALUE = 32'h0101_0048
)
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Power state from the core
  input wire logic sleep_i,
  input wire logic deep_sleep_i,
  // Accesses toward the gated units: one request flag per unit
  input wire logic [6:0] unit_access_i,
  output logic [6:0] unit_fault_o,
  // Clock enables to the gated units: port a..e, dma, usb
  output logic [6:0] unit_clk_en_o,
  // Unit resets
  output logic can_unit_reset_o,
  output logic adc_reset_o,
  output logic hibernation_reset_o,
  output logic watchdog_reset_o,
  // Interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] run_clock_gate_2;
  logic [31:0] sleep_clock_gate_2;
  logic [31:0] deep_sleep_clock_gate_2;
  logic [31:0] software_reset_control_0;
  logic [31:0] run_mode_clock_config;
  logic [31:0] irq_status;
  logic [31:0] irq_mask;
  logic ack;
  logic [31:0] rdata;
  logic [6:0] unit_clk_en;
  logic [6:0] unit_fault;
  dsgr_pkg::dsgr_mode_type mode;
  dsgr_pkg::dsgr_mode_type mode_q;

  logic [31:0] next_run_clock_gate_2;
  logic [31:0] next_sleep_clock_gate_2;
  logic [31:0] next_deep_sleep_clock_gate_2;
  logic [31:0] next_software_reset_control_0;
  logic [31:0] next_run_mode_clock_config;
  logic [31:0] next_irq_status;
  logic [31:0] next_irq_mask;
  logic next_ack;
  logic [31:0] next_rdata;
  logic [6:0] next_unit_clk_en;
  logic [6:0] next_unit_fault;

  logic [31:0] bmask;
  logic wr;
  logic [31:0] sel_gate;
  logic [6:0] gate_units;

  ////////////////////////////////////////////////////////////////////////////
  // Effective mode: sleep gates only honoured when auto gating is selected
  always_comb
  begin
    if (run_mode_clock_config[dsgr_pkg::AUTO_GATE_BIT] && deep_sleep_i)
      mode = dsgr_pkg::DSGR_DEEP;
    else if (run_mode_clock_config[dsgr_pkg::AUTO_GATE_BIT] && sleep_i)
      mode = dsgr_pkg::DSGR_SLEEP;
    else
      mode = dsgr_pkg::DSGR_RUN;
  end

  always_comb
  begin
    unique case (mode)
      dsgr_pkg::DSGR_DEEP: sel_gate = deep_sleep_clock_gate_2;
      dsgr_pkg::DSGR_SLEEP: sel_gate = sleep_clock_gate_2;
      default: sel_gate = run_clock_gate_2;
    endcase
  end

  // Unit order: ports a..e, then dma, then usb
  assign gate_units = {sel_gate[dsgr_pkg::GATE_USB_BIT], sel_gate[dsgr_pkg::GATE_DMA_BIT],
                       sel_gate[dsgr_pkg::GATE_PORT_LSB +: dsgr_pkg::GATE_PORTS]};

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane write mask
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign bmask[g*8 +: 8] = {8{sel_i[g]}};
    end
  endgenerate

  // Classic single-cycle answer; ack drops the cycle after it was given
  assign wr = cyc_i && stb_i && we_i && !ack;

  always_comb
  begin
    next_run_clock_gate_2 = run_clock_gate_2;
    next_sleep_clock_gate_2 = sleep_clock_gate_2;
    next_deep_sleep_clock_gate_2 = deep_sleep_clock_gate_2;
    next_software_reset_control_0 = software_reset_control_0;
    next_run_mode_clock_config = run_mode_clock_config;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_ack = cyc_i && stb_i && !ack;
    next_rdata = 32'h0000_0000;
    next_unit_clk_en = gate_units;
    next_unit_fault = unit_access_i & ~gate_units;
    if (wr)
    begin
      unique case (adr_i)
        dsgr_pkg::OFF_RUN_GATE_2:
          next_run_clock_gate_2 = (run_clock_gate_2 & ~(bmask & dsgr_pkg::GATE_WMASK)) |
                                  (dat_i & bmask & dsgr_pkg::GATE_WMASK);
        dsgr_pkg::OFF_SLEEP_GATE_2:
          next_sleep_clock_gate_2 = (sleep_clock_gate_2 & ~(bmask & dsgr_pkg::GATE_WMASK)) |
                                    (dat_i & bmask & dsgr_pkg::GATE_WMASK);
        dsgr_pkg::OFF_DEEP_SLEEP_GATE_2:
          next_deep_sleep_clock_gate_2 = (deep_sleep_clock_gate_2 & ~(bmask & dsgr_pkg::GATE_WMASK)) |
                                         (dat_i & bmask & dsgr_pkg::GATE_WMASK);
        dsgr_pkg::OFF_SW_RESET_0:
          next_software_reset_control_0 = (software_reset_control_0 &
                                           ~(bmask & dsgr_pkg::RST_WMASK & CAPS_1_VALUE)) |
                                          (dat_i & bmask & dsgr_pkg::RST_WMASK & CAPS_1_VALUE);
        dsgr_pkg::OFF_RUN_CONFIG:
          next_run_mode_clock_config = (run_mode_clock_config & ~(bmask & dsgr_pkg::RUNCFG_WMASK)) |
                                       (dat_i & bmask & dsgr_pkg::RUNCFG_WMASK);
        dsgr_pkg::OFF_IRQ_MASK:
          next_irq_mask = (irq_mask & ~(bmask & dsgr_pkg::IRQ_WMASK)) | (dat_i & bmask & dsgr_pkg::IRQ_WMASK);
        dsgr_pkg::OFF_IRQ_STATUS:
          next_irq_status = irq_status & ~(dat_i & bmask & dsgr_pkg::IRQ_WMASK);
        default:
          next_irq_status = irq_status;
      endcase
    end
    // Set after clear so an event in the clearing cycle survives
    if (|unit_fault)
      next_irq_status[dsgr_pkg::EV_FAULT_BIT] = 1'b1;
    if (mode != mode_q)
      next_irq_status[dsgr_pkg::EV_MODE_BIT] = 1'b1;
    if (cyc_i && stb_i && !we_i && !ack)
    begin
      unique case (adr_i)
        dsgr_pkg::OFF_RUN_GATE_2: next_rdata = run_clock_gate_2;
        dsgr_pkg::OFF_SLEEP_GATE_2: next_rdata = sleep_clock_gate_2;
        dsgr_pkg::OFF_DEEP_SLEEP_GATE_2: next_rdata = deep_sleep_clock_gate_2;
        dsgr_pkg::OFF_SW_RESET_0: next_rdata = software_reset_control_0;
        dsgr_pkg::OFF_RUN_CONFIG: next_rdata = run_mode_clock_config;
        dsgr_pkg::OFF_CAPS_1: next_rdata = CAPS_1_VALUE;
        dsgr_pkg::OFF_IRQ_STATUS: next_rdata = irq_status;
        dsgr_pkg::OFF_IRQ_MASK: next_rdata = irq_mask;
        // Unmapped addresses read zero and still ack, so software never hangs
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_clock_gate_2 <= dsgr_pkg::GATE_RESET;
      sleep_clock_gate_2 <= dsgr_pkg::GATE_RESET;
      deep_sleep_clock_gate_2 <= dsgr_pkg::GATE_RESET;
      software_reset_control_0 <= dsgr_pkg::RST_RESET;
      run_mode_clock_config <= 32'h0000_0000;
      irq_status <= 32'h0000_0000;
      irq_mask <= 32'h0000_0000;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      unit_clk_en <= 7'h00;
      unit_fault <= 7'h00;
      mode_q <= dsgr_pkg::DSGR_RUN;
    end
    else
    begin
      run_clock_gate_2 <= next_run_clock_gate_2;
      sleep_clock_gate_2 <= next_sleep_clock_gate_2;
      deep_sleep_clock_gate_2 <= next_deep_sleep_clock_gate_2;
      software_reset_control_0 <= next_software_reset_control_0;
      run_mode_clock_config <= next_run_mode_clock_config;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      ack <= next_ack;
      rdata <= next_rdata;
      unit_clk_en <= next_unit_clk_en;
      unit_fault <= next_unit_fault;
      mode_q <= mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ack_o = ack;
  assign dat_o = rdata;
  assign unit_clk_en_o = unit_clk_en;
  assign unit_fault_o = unit_fault;
  // Each reset follows its own bit only, held until software clears it
  assign can_unit_reset_o = software_reset_control_0[dsgr_pkg::RST_CAN_BIT];
  assign adc_reset_o = software_reset_control_0[dsgr_pkg::RST_ADC_BIT];
  assign hibernation_reset_o = software_reset_control_0[dsgr_pkg::RST_HIBERNATE_BIT];
  assign watchdog_reset_o = software_reset_control_0[dsgr_pkg::RST_WATCHDOG_BIT];
  assign irq_o = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr_deep;
    cyc_i && stb_i && we_i && !ack && adr_i == dsgr_pkg::OFF_DEEP_SLEEP_GATE_2 && sel_i == 4'hf;
  endsequence

  property p_deep_write;
    @(posedge clk_i) disable iff (rst_i)
    s_wr_deep |=> deep_sleep_clock_gate_2 == ($past(dat_i) & dsgr_pkg::GATE_WMASK);
  endproperty
  a_deep_write: assert property (p_deep_write) else $error("deep gate write wrong");

  property p_reserved_zero;
    @(posedge clk_i) disable iff (rst_i)
    (deep_sleep_clock_gate_2 & ~dsgr_pkg::GATE_WMASK) == 32'h0000_0000 &&
    (sleep_clock_gate_2 & ~dsgr_pkg::GATE_WMASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved gate bits set");

  property p_clk_follows;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |=> unit_clk_en_o == $past(gate_units);
  endproperty
  a_clk_follows: assert property (p_clk_follows) else $error("unit clock enable mismatch");

  property p_fault_gated;
    @(posedge clk_i) disable iff (rst_i)
    unit_access_i[0] && !gate_units[0] |=> unit_fault_o[0];
  endproperty
  a_fault_gated: assert property (p_fault_gated) else $error("no fault on gated access");

  property p_no_fault_clocked;
    @(posedge clk_i) disable iff (rst_i)
    gate_units[0] |=> !unit_fault_o[0];
  endproperty
  a_no_fault_clocked: assert property (p_no_fault_clocked) else $error("fault on clocked unit");

  property p_deep_select;
    @(posedge clk_i) disable iff (rst_i)
    deep_sleep_i && run_mode_clock_config[dsgr_pkg::AUTO_GATE_BIT] |->
      gate_units[6] == deep_sleep_clock_gate_2[dsgr_pkg::GATE_USB_BIT];
  endproperty
  a_deep_select: assert property (p_deep_select) else $error("deep gate not selected");

  property p_auto_off_run;
    @(posedge clk_i) disable iff (rst_i)
    !run_mode_clock_config[dsgr_pkg::AUTO_GATE_BIT] |-> sel_gate == run_clock_gate_2;
  endproperty
  a_auto_off_run: assert property (p_auto_off_run) else $error("sleep gate without auto select");

  property p_rst_masked;
    @(posedge clk_i) disable iff (rst_i)
    (software_reset_control_0 & ~(dsgr_pkg::RST_WMASK & CAPS_1_VALUE)) == 32'h0000_0000;
  endproperty
  a_rst_masked: assert property (p_rst_masked) else $error("masked reset bit set");

  property p_wdt_hold;
    @(posedge clk_i) disable iff (rst_i)
    watchdog_reset_o && !(wr && adr_i == dsgr_pkg::OFF_SW_RESET_0) |=> watchdog_reset_o;
  endproperty
  a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog reset dropped");

endmodule

// ===== testbench/dsgr_tb_top.sv
// Self-checking bench for the sleep gating and soft reset block
`timescale 1ns/1ps
module dsgr_tb_top;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;} dsgr_row_type;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic sleep_i = 1'b0;
  logic deep_sleep_i = 1'b0;
  logic [6:0] unit_access_i = 7'h00;
  logic [31:0] dat_o;
  logic ack_o;
  logic [6:0] unit_fault_o;
  logic [6:0] unit_clk_en_o;
  logic can_unit_reset_o, adc_reset_o, hibernation_reset_o, watchdog_reset_o;
  logic irq_o;
  logic [6:0] unit_rst;
  logic [31:0] rd;
  int n_errors = 0;
  int n_compared = 0;
  // Last row relies on the gate value left by the second row: byte lane 0 only
  dsgr_row_type rows [6] = '{
    '{dsgr_pkg::OFF_SW_RESET_0, 32'hffff_ffff, 4'hf, 32'h0101_0048},
    '{dsgr_pkg::OFF_DEEP_SLEEP_GATE_2, 32'hffff_ffff, 4'hf, 32'h0001_201f},
    '{dsgr_pkg::OFF_SLEEP_GATE_2, 32'hffff_ffff, 4'hf, 32'h0001_201f},
    '{dsgr_pkg::OFF_CAPS_1, 32'h0000_0000, 4'hf, 32'h0101_0048},
    '{12'h3fc, 32'hffff_ffff, 4'hf, 32'h0000_0000},
    '{dsgr_pkg::OFF_DEEP_SLEEP_GATE_2, 32'h0000_0000, 4'h1, 32'h0001_2000}
  };

  assign unit_rst = {3'h0, can_unit_reset_o, adc_reset_o, hibernation_reset_o, watchdog_reset_o};

  always #5 clk_i = ~clk_i;

  dsgr_top dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sleep_i(sleep_i),
    .deep_sleep_i(deep_sleep_i), .unit_access_i(unit_access_i), .unit_fault_o(unit_fault_o),
    .unit_clk_en_o(unit_clk_en_o), .can_unit_reset_o(can_unit_reset_o), .adc_reset_o(adc_reset_o),
    .hibernation_reset_o(hibernation_reset_o), .watchdog_reset_o(watchdog_reset_o), .irq_o(irq_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bits(input logic [6:0] got, input logic [6:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until ack is seen at an edge; only the watchdog ends a hung wait
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000, 4'hf);
    chk_word(rd, e);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic end_sim();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    n_errors++;
    end_sim();
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_n(1);
    chk_bits(unit_clk_en_o, 7'h00);
    rd_chk(dsgr_pkg::OFF_DEEP_SLEEP_GATE_2, 32'h0000_0000);
    rd_chk(dsgr_pkg::OFF_SW_RESET_0, 32'h0000_0000);
    foreach (rows[i])
    begin
      wb(1'b1, rows[i].a, rows[i].d, rows[i].s);
      rd_chk(rows[i].a, rows[i].e);
    end
    chk_bits(unit_rst, 7'h0f);
    wb(1'b1, dsgr_pkg::OFF_SW_RESET_0, 32'h0000_0040, 4'hf);
    wait_n(1);
    chk_bits(unit_rst, 7'h02);
    wb(1'b1, dsgr_pkg::OFF_SW_RESET_0, 32'h0000_0008, 4'hf);
    wait_n(1);
    chk_bits(unit_rst, 7'h01);
    wb(1'b1, dsgr_pkg::OFF_SW_RESET_0, 32'h0000_0000, 4'hf);
    wait_n(1);
    chk_bits(unit_rst, 7'h00);
    // Auto gating still off: deep sleep must not pick the deep gate
    @(posedge clk_i);
    deep_sleep_i <= 1'b1;
    wait_n(2);
    chk_bits(unit_clk_en_o, 7'h00);
    wb(1'b1, dsgr_pkg::OFF_RUN_CONFIG, 32'h0800_0000, 4'hf);
    wait_n(2);
    chk_bits(unit_clk_en_o, 7'h60);
    // Both power states high: deep sleep wins
    @(posedge clk_i);
    sleep_i <= 1'b1;
    wait_n(2);
    chk_bits(unit_clk_en_o, 7'h60);
    @(posedge clk_i);
    deep_sleep_i <= 1'b0;
    wait_n(2);
    chk_bits(unit_clk_en_o, 7'h7f);
    @(posedge clk_i);
    sleep_i <= 1'b0;
    wait_n(2);
    chk_bits(unit_clk_en_o, 7'h00);
    wb(1'b1, dsgr_pkg::OFF_RUN_GATE_2, 32'h0000_0001, 4'hf);
    wait_n(2);
    chk_bits(unit_clk_en_o, 7'h01);
    @(posedge clk_i);
    unit_access_i <= 7'h03;
    @(posedge clk_i);
    unit_access_i <= 7'h00;
    #1;
    chk_bits(unit_fault_o, 7'h02);
    rd_chk(dsgr_pkg::OFF_IRQ_STATUS, 32'h0000_0003);
    wb(1'b1, dsgr_pkg::OFF_IRQ_MASK, 32'h0000_0001, 4'hf);
    wait_n(2);
    chk_bits({6'h00, irq_o}, 7'h01);
    wb(1'b1, dsgr_pkg::OFF_IRQ_STATUS, 32'h0000_0001, 4'hf);
    wait_n(2);
    chk_bits({6'h00, irq_o}, 7'h00);
    rd_chk(dsgr_pkg::OFF_IRQ_STATUS, 32'h0000_0002);
    wb(1'b1, dsgr_pkg::OFF_IRQ_MASK, 32'h0000_0003, 4'hf);
    wait_n(2);
    chk_bits({6'h00, irq_o}, 7'h01);
    wb(1'b1, dsgr_pkg::OFF_IRQ_STATUS, 32'h0000_0003, 4'hf);
    wait_n(2);
    chk_bits({6'h00, irq_o}, 7'h00);
    // Second reset in mid-run with port a clocked
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_n(1);
    chk_bits(unit_clk_en_o, 7'h00);
    rd_chk(dsgr_pkg::OFF_DEEP_SLEEP_GATE_2, 32'h0000_0000);
    rd_chk(dsgr_pkg::OFF_SW_RESET_0, 32'h0000_0000);
    end_sim();
  end
endmodule
